// File: tal_alert.sv
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module tal_alert
	import tal_pkg::*;
(
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic               conv_done,
	input  wire logic               conv_busy,
	input  wire logic signed [13:0] remote_raw,
	input  wire logic [7:0]         local_temperature,
	input  wire logic               diode_short_vdd,
	input  wire logic               diode_open,
	input  wire logic               diode_short_gnd,
	input  wire logic               smb_clk_i,
	input  wire logic               smb_dat_i,
	output logic                    smb_dat_o,
	output logic                    smb_dat_oe,
	input  wire logic               alert_n_i,
	output logic                    alert_n_o,
	output logic                    alert_n_oe,
	input  wire logic               critical_temp_output_n_i,
	output logic                    critical_temp_output_n_o,
	output logic                    critical_temp_output_n_oe
);

	// Bus access state.
	logic        rd_pend_reg, rd_pend_next;   // Read data phase waiting.
	logic [7:0]  rd_addr_reg, rd_addr_next;   // Address of pending read.
	logic        wr_pend_reg, wr_pend_next;   // Write data phase pending.
	logic [7:0]  wr_addr_reg, wr_addr_next;   // Address of pending write.
	logic [31:0] hrdata_reg, hrdata_next;     // Registered read data.

	// Software-visible registers; the live limit conditions are internal.
	logic [TAL_CFG_W-1:0] cfg_reg, cfg_next;  // Configuration bits.
	logic [7:0]  lhigh_reg, lhigh_next;       // Local high setpoint.
	logic [15:0] rhigh_reg, rhigh_next;       // Remote high setpoint.
	logic [15:0] rlow_reg, rlow_next;         // Remote low setpoint.
	logic [7:0]  crit_set_reg, crit_set_next; // Critical setpoint.
	logic [7:0]  hyst_reg, hyst_next;         // Critical hysteresis.
	logic [15:0] rtemp_reg, rtemp_next;       // Remote reading word.
	logic [7:0]  ltemp_reg, ltemp_next;       // Local reading.
	logic [2:0]  fault_reg, fault_next;       // Diode fault kinds.
	logic [3:0]  sticky_reg, sticky_next;     // Sticky fault/low/high bits.
	logic [2:0]  cond_reg, cond_next;         // Live limit conditions.
	logic        crit_reg, crit_next;         // Critical status bit.

	// Synchronisers for the pins from outside the clock domain.
	logic [1:0]  scl_sync, sda_sync, aln_sync, crn_sync;
	logic        scl_d_reg, sda_d_reg;        // Previous synced levels.

	// SMBus slave state.
	tal_smb_state_t smb_reg, smb_next;
	logic [3:0]  bit_cnt_reg, bit_cnt_next;   // Bits moved in this byte.
	logic [7:0]  shift_reg, shift_next;       // Received or sent byte.
	logic        drive_reg, drive_next;       // Pull data line low.

	// Combinational helpers.
	logic        rd_accept, wr_accept, status_read, ara_won;
	logic        scl_rise, scl_fall, start_seen, stop_seen;
	logic        alert_active, alerting_bits;
	logic signed [13:0] clamped, rhigh_ext, rlow_ext;
	logic signed [9:0]  rint, crit_ext, crit_clr;

	// Open-drain pins only ever pull low.
	assign smb_dat_o                 = 1'b0;
	assign alert_n_o                 = 1'b0;
	assign critical_temp_output_n_o  = 1'b0;
	assign smb_dat_oe                = drive_reg;
	assign critical_temp_output_n_oe = crit_reg;
	assign hrdata                    = hrdata_reg;
	assign hreadyout                 = ~rd_pend_reg;
	assign hresp                     = 1'b0;

	// A transfer is taken in its address phase while the bus is ready.
	assign rd_accept   = hsel & htrans[1] & hready & ~hwrite;
	assign wr_accept   = hsel & htrans[1] & hready & hwrite;
	// The read side effect fires once, at the end of the wait state.
	assign status_read = rd_pend_reg & (rd_addr_reg == TAL_OFS_STATUS);

	// Bits that can pull the alert line: never busy or the diode fault.
	assign alerting_bits = |sticky_reg[3:1] | crit_reg;

	// Alert level: sticky bits in interrupt mode, live ones in comparator.
	always_comb begin
		if (cfg_reg[TAL_CFG_COMP]) begin
			alert_active = (|cond_reg) | crit_reg;
		end else begin
			alert_active = alerting_bits;
		end
		alert_n_oe = alert_active & ~cfg_reg[TAL_CFG_MASK];
	end

	// Remote reading forms and setpoint extensions; limits in 1/32 degree units, critical compare in whole degrees.
	always_comb begin
		if (cfg_reg[TAL_CFG_USF]) begin
			clamped = (remote_raw < 14'sd0) ? 14'sd0 : remote_raw;
		end else if (remote_raw > TAL_S_MAX) begin
			clamped = TAL_S_MAX;
		end else if (remote_raw < TAL_S_MIN) begin
			clamped = TAL_S_MIN;
		end else begin
			clamped = remote_raw;
		end
		if (cfg_reg[TAL_CFG_USF]) begin
			rhigh_ext = $signed({1'b0, rhigh_reg[15:3]});
			rlow_ext  = $signed({1'b0, rlow_reg[15:3]});
			crit_ext  = $signed({2'b00, crit_set_reg});
		end else begin
			rhigh_ext = $signed({rhigh_reg[15], rhigh_reg[15:3]});
			rlow_ext  = $signed({rlow_reg[15], rlow_reg[15:3]});
			crit_ext  = $signed({{2{crit_set_reg[7]}}, crit_set_reg});
		end
		rint     = $signed({remote_raw[13], remote_raw[13:5]});
		crit_clr = crit_ext - $signed({2'b00, hyst_reg});
	end

	// Bus front end: capture address phases, hold read data.
	always_comb begin
		rd_pend_next = rd_accept;
		rd_addr_next = rd_accept ? haddr[7:0] : rd_addr_reg;
		wr_pend_next = wr_accept;
		wr_addr_next = wr_accept ? haddr[7:0] : wr_addr_reg;
		hrdata_next  = hrdata_reg;
		// Read data is built in the wait state, after any earlier write.
		if (rd_pend_reg) begin
			case (rd_addr_reg)
				TAL_OFS_CONFIG:     hrdata_next = {26'h0, cfg_reg};
				TAL_OFS_STATUS:     hrdata_next = {24'h0, conv_busy,
					sticky_reg[3], 1'b0, sticky_reg[2], sticky_reg[1],
					1'b0, crit_reg, sticky_reg[0]};
				TAL_OFS_LOCAL_HIGH: hrdata_next = {24'h0, lhigh_reg};
				TAL_OFS_REM_HIGH:   hrdata_next = {16'h0, rhigh_reg};
				TAL_OFS_REM_LOW:    hrdata_next = {16'h0, rlow_reg};
				TAL_OFS_CRIT_SET:   hrdata_next = {24'h0, crit_set_reg};
				TAL_OFS_CRIT_HYST:  hrdata_next = {24'h0, hyst_reg};
				TAL_OFS_REM_TEMP:   hrdata_next = {16'h0, rtemp_reg};
				TAL_OFS_LOCAL_TEMP: hrdata_next = {24'h0, ltemp_reg};
				TAL_OFS_FAULT:      hrdata_next = {29'h0, fault_reg};
				TAL_OFS_LINES:      hrdata_next = {30'h0, crn_sync[1],
					aln_sync[1]};
				// Unmapped words read as zero with an OKAY answer.
				default:            hrdata_next = 32'h0000_0000;
			endcase
		end
	end

	// Register file, conversion results and alert bookkeeping.
	always_comb begin
		cfg_next      = cfg_reg;
		lhigh_next    = lhigh_reg;
		rhigh_next    = rhigh_reg;
		rlow_next     = rlow_reg;
		crit_set_next = crit_set_reg;
		hyst_next     = hyst_reg;
		rtemp_next    = rtemp_reg;
		ltemp_next    = ltemp_reg;
		fault_next    = fault_reg;
		sticky_next   = sticky_reg;
		cond_next     = cond_reg;
		crit_next     = crit_reg;
		// Software writes land in the write data phase.
		if (wr_pend_reg) begin
			case (wr_addr_reg)
				TAL_OFS_CONFIG:     cfg_next   = hwdata[TAL_CFG_W-1:0];
				TAL_OFS_LOCAL_HIGH: lhigh_next = hwdata[7:0];
				TAL_OFS_REM_HIGH:   rhigh_next = hwdata[15:0] & 16'hFFE0;
				TAL_OFS_REM_LOW:    rlow_next  = hwdata[15:0] & 16'hFFE0;
				TAL_OFS_CRIT_SET: begin
					if (cfg_reg[TAL_CFG_OVERRIDE]) begin
						crit_set_next = hwdata[7:0];
					end
				end
				TAL_OFS_CRIT_HYST:  hyst_next  = hwdata[7:0];
				// Read-only and unmapped words ignore writes.
				default: ;
			endcase
		end
		if (status_read) begin
			sticky_next = 4'h0;
		end
		if (status_read && !cfg_reg[TAL_CFG_COMP] && alerting_bits) begin
			cfg_next[TAL_CFG_MASK] = 1'b1;
		end
		if (ara_won) begin
			cfg_next[TAL_CFG_MASK] = 1'b1;
		end
		// End of conversion; setting wins over a read in the same cycle.
		if (conv_done) begin
			rtemp_next = {clamped[12:0], 3'b000};
			if (!cfg_reg[TAL_CFG_FILTER]) begin
				rtemp_next = {clamped[12:0], 3'b000} & TAL_NOFILT_MASK;
			end
			ltemp_next = local_temperature;
			fault_next = {diode_short_gnd, diode_open, diode_short_vdd};
			cond_next[2] = $signed(local_temperature) > $signed(lhigh_reg);
			cond_next[1] = remote_raw > rhigh_ext;
			cond_next[0] = remote_raw < rlow_ext;
			sticky_next  = sticky_next | {cond_next[2], cond_next[1],
				cond_next[0], |fault_next};
			if (rint > crit_ext) begin
				crit_next = 1'b1;
			end else if (rint <= crit_clr) begin
				crit_next = 1'b0;
			end
		end
	end

	// Edge and bus-condition detection on the synchronised SMBus lines.
	always_comb begin
		scl_rise   = scl_sync[1] & ~scl_d_reg;
		scl_fall   = ~scl_sync[1] & scl_d_reg;
		start_seen = scl_sync[1] & scl_d_reg & sda_d_reg & ~sda_sync[1];
		stop_seen  = scl_sync[1] & scl_d_reg & ~sda_d_reg & sda_sync[1];
	end

	// SMBus slave: answers the alert response address only.
	// clock only sampled
	always_comb begin
		smb_next     = smb_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next   = shift_reg;
		drive_next   = drive_reg;
		ara_won      = 1'b0;
		case (smb_reg)
			TAL_SMB_IDLE: begin
				drive_next = 1'b0;
			end
			TAL_SMB_ADDR: begin
				// Shift the address byte in on rising clock edges.
				if (scl_rise) begin
					shift_next   = {shift_reg[6:0], sda_sync[1]};
					bit_cnt_next = bit_cnt_reg + 4'd1;
				end else if (scl_fall && bit_cnt_reg == 4'd8) begin
					if (shift_reg == {TAL_ARA_ADDR, 1'b1} &&
					    alert_n_oe && !cfg_reg[TAL_CFG_ALERTCFG]) begin
						smb_next   = TAL_SMB_ACK;
						drive_next = 1'b1;
					end else begin
						smb_next = TAL_SMB_IDLE;
					end
				end
			end
			TAL_SMB_ACK: begin
				// After the acknowledge bit, put the first address bit on.
				if (scl_fall) begin
					shift_next   = {TAL_OWN_ADDR, 1'b1};
					bit_cnt_next = 4'd0;
					drive_next   = ~TAL_OWN_ADDR[6];
					smb_next     = TAL_SMB_SEND;
				end
			end
			TAL_SMB_SEND: begin
				if (scl_rise) begin
					if (shift_reg[7] && !sda_sync[1]) begin
						smb_next   = TAL_SMB_IDLE;
						drive_next = 1'b0;
					end else if (bit_cnt_reg == 4'd7) begin
						ara_won  = 1'b1;
						smb_next = TAL_SMB_DONE;
					end else begin
						bit_cnt_next = bit_cnt_reg + 4'd1;
					end
				end else if (scl_fall) begin
					// Next bit goes out while the clock is low.
					shift_next = {shift_reg[6:0], 1'b1};
					drive_next = ~shift_reg[6];
				end
			end
			TAL_SMB_DONE: begin
				// Release the line for the master's not-acknowledge.
				if (scl_fall) begin
					drive_next = 1'b0;
					smb_next   = TAL_SMB_IDLE;
				end
			end
			default: begin
				smb_next   = TAL_SMB_IDLE;
				drive_next = 1'b0;
			end
		endcase
		// A start restarts address reception from any point.
		if (start_seen) begin
			smb_next     = TAL_SMB_ADDR;
			bit_cnt_next = 4'd0;
			drive_next   = 1'b0;
		end else if (stop_seen) begin
			smb_next   = TAL_SMB_IDLE;
			drive_next = 1'b0;
		end
	end

	// Two flip-flop synchronisers; only the second stage is read.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_sync  <= 2'b11;
			sda_sync  <= 2'b11;
			aln_sync  <= 2'b11;
			crn_sync  <= 2'b11;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_sync  <= {scl_sync[0], smb_clk_i};
			sda_sync  <= {sda_sync[0], smb_dat_i};
			aln_sync  <= {aln_sync[0], alert_n_i};
			crn_sync  <= {crn_sync[0], critical_temp_output_n_i};
			scl_d_reg <= scl_sync[1];
			sda_d_reg <= sda_sync[1];
		end
	end

	// Bus front end registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_pend_reg <= 1'b0;
			rd_addr_reg <= 8'h00;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg  <= 32'h0000_0000;
		end else begin
			rd_pend_reg <= rd_pend_next;
			rd_addr_reg <= rd_addr_next;
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			hrdata_reg  <= hrdata_next;
		end
	end

	// Register file registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_reg      <= TAL_RST_CONFIG;
			lhigh_reg    <= TAL_RST_LOCAL_HIGH;
			rhigh_reg    <= TAL_RST_REM_HIGH;
			rlow_reg     <= TAL_RST_REM_LOW;
			crit_set_reg <= TAL_RST_CRIT_SET;
			hyst_reg     <= TAL_RST_CRIT_HYST;
			rtemp_reg    <= 16'h0000;
			ltemp_reg    <= 8'h00;
			fault_reg    <= 3'h0;
			sticky_reg   <= 4'h0;
			cond_reg     <= 3'h0;
			crit_reg     <= 1'b0;
		end else begin
			cfg_reg      <= cfg_next;
			lhigh_reg    <= lhigh_next;
			rhigh_reg    <= rhigh_next;
			rlow_reg     <= rlow_next;
			crit_set_reg <= crit_set_next;
			hyst_reg     <= hyst_next;
			rtemp_reg    <= rtemp_next;
			ltemp_reg    <= ltemp_next;
			fault_reg    <= fault_next;
			sticky_reg   <= sticky_next;
			cond_reg     <= cond_next;
			crit_reg     <= crit_next;
		end
	end

	// SMBus slave registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			smb_reg     <= TAL_SMB_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 8'h00;
			drive_reg   <= 1'b0;
		end else begin
			smb_reg     <= smb_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg   <= shift_next;
			drive_reg   <= drive_next;
		end
	end

endmodule : tal_alert

`default_nettype wire

// File: tal_alert_props.sv
`timescale 1ns/100ps
`default_nettype none
// Watches the bus answer timing, the open-drain pins and the alert causes.
module tal_alert_props (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        conv_done,
	input wire logic        smb_clk_i,
	input wire logic        smb_dat_o,
	input wire logic        smb_dat_oe,
	input wire logic        alert_n_o,
	input wire logic        alert_n_oe,
	input wire logic        critical_temp_output_n_o,
	input wire logic        critical_temp_output_n_oe
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic take;          // A transfer is taken at this edge.
	logic wdp_reg;       // High during a write data phase.
	logic wdp_next;      // Next value of the write data phase flag.

	// Config writes land at the end of the data phase, so track it.
	always_comb begin
		take     = hsel && htrans[1] && hready;
		wdp_next = take && hwrite;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdp_reg <= 1'b0;
		end else begin
			wdp_reg <= wdp_next;
		end
	end

	AST_HRESP_OKAY: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	AST_READ_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	AST_WRITE_NOWAIT: assert property (take && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	AST_HRDATA_HOLD: assert property ($changed(hrdata) |-> hreadyout && !$past(hreadyout))
		else $error("read data moved outside a read");
	AST_OPEN_DRAIN: assert property (!smb_dat_o && !alert_n_o && !critical_temp_output_n_o)
		else $error("open-drain pin drives high");
	AST_DAT_SCL_LOW: assert property ($changed(smb_dat_oe) |-> !smb_clk_i)
		else $error("data line moved while clock high");
	AST_CRIT_CONV: assert property ($changed(critical_temp_output_n_oe) |-> $past(conv_done))
		else $error("critical output moved without a conversion");
	AST_ALERT_CAUSE: assert property ($rose(alert_n_oe) |-> $past(conv_done) || $past(wdp_reg))
		else $error("alert asserted without a cause");

	cover property ($fell(alert_n_oe));
	cover property ($rose(critical_temp_output_n_oe));
	cover property ($rose(smb_dat_oe));
endmodule : tal_alert_props

bind tal_alert tal_alert_props tal_alert_props_i (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv_done(conv_done),
	.smb_clk_i(smb_clk_i), .smb_dat_o(smb_dat_o), .smb_dat_oe(smb_dat_oe),
	.alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe),
	.critical_temp_output_n_o(critical_temp_output_n_o),
	.critical_temp_output_n_oe(critical_temp_output_n_oe));
`default_nettype wire

// File: tal_pkg.sv
// Shared constants for the temperature alert and critical output block.
package tal_pkg;

	// Register byte offsets on the AHB-Lite bus, one word each.
	localparam logic [7:0] TAL_OFS_CONFIG     = 8'h00;
	localparam logic [7:0] TAL_OFS_STATUS     = 8'h04;
	localparam logic [7:0] TAL_OFS_LOCAL_HIGH = 8'h08;
	localparam logic [7:0] TAL_OFS_REM_HIGH   = 8'h0C;
	localparam logic [7:0] TAL_OFS_REM_LOW    = 8'h10;
	localparam logic [7:0] TAL_OFS_CRIT_SET   = 8'h14;
	localparam logic [7:0] TAL_OFS_CRIT_HYST  = 8'h18;
	localparam logic [7:0] TAL_OFS_REM_TEMP   = 8'h1C;
	localparam logic [7:0] TAL_OFS_LOCAL_TEMP = 8'h20;
	localparam logic [7:0] TAL_OFS_FAULT      = 8'h24;
	localparam logic [7:0] TAL_OFS_LINES      = 8'h28;

	// Configuration register field positions.
	localparam int TAL_CFG_MASK     = 0;
	localparam int TAL_CFG_OVERRIDE = 1;
	localparam int TAL_CFG_COMP     = 2;
	localparam int TAL_CFG_ALERTCFG = 3;
	localparam int TAL_CFG_USF      = 4;
	localparam int TAL_CFG_FILTER   = 5;
	localparam int TAL_CFG_W        = 6;

	// Status register field positions.
	localparam int TAL_ST_FAULT = 0;
	localparam int TAL_ST_CRIT  = 1;
	localparam int TAL_ST_RLOW  = 3;
	localparam int TAL_ST_RHIGH = 4;
	localparam int TAL_ST_LHIGH = 6;
	localparam int TAL_ST_BUSY  = 7;

	// Reset values of the writable registers.
	localparam logic [TAL_CFG_W-1:0] TAL_RST_CONFIG = 6'h00;
	localparam logic [7:0]  TAL_RST_LOCAL_HIGH = 8'h46;
	localparam logic [15:0] TAL_RST_REM_HIGH   = 16'h4600;
	localparam logic [15:0] TAL_RST_REM_LOW    = 16'h0000;
	localparam logic [7:0]  TAL_RST_CRIT_SET   = 8'h55;
	localparam logic [7:0]  TAL_RST_CRIT_HYST  = 8'h0A;

	// SMBus addresses: alert response address and the fixed own address.
	localparam logic [6:0] TAL_ARA_ADDR = 7'h0C;
	localparam logic [6:0] TAL_OWN_ADDR = 7'h4C;

	// Reading limits in 1/32 degree units, and the low-bit mask without filter.
	localparam logic signed [13:0] TAL_S_MAX = 14'sh0FFF;
	localparam logic signed [13:0] TAL_S_MIN = 14'sh3000;
	localparam logic [15:0] TAL_NOFILT_MASK = 16'hFFE0;

	// SMBus slave states.
	typedef enum logic [2:0] {
		TAL_SMB_IDLE = 3'b000,
		TAL_SMB_ADDR = 3'b001,
		TAL_SMB_ACK  = 3'b010,
		TAL_SMB_SEND = 3'b011,
		TAL_SMB_DONE = 3'b100
	} tal_smb_state_t;

endpackage : tal_pkg

// File: tal_smb_host.sv
`timescale 1ns/100ps
`default_nettype none
// Bus host that runs alert response reads; clock stands high between frames.
module tal_smb_host (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	initial begin
		scl     = 1'b1;
		sda_low = 1'b0;
	end

	// One bit: 500 ns low, 300 ns high, sampled mid-high.
	task automatic clk_bit(input logic low, output logic s);
		sda_low = low;
		#300 scl = 1'b1;
		#150 s = sda;
		#150 scl = 1'b0;
		#200;
	endtask : clk_bit

	// start, read, nack, stop.
	// A bit index in bad is pulled low to break the slave's address.
	task automatic ara(input int bad, output logic ack, output logic [7:0] rx);
		logic s;
		sda_low = 1'b1;
		#400 scl = 1'b0;
		#200;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(!(8'h19 >> i & 8'h01), s);
		end
		clk_bit(1'b0, s);
		ack = !s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(i == bad, rx[i]);
		end
		clk_bit(1'b0, s);
		sda_low = 1'b1;
		#200 scl = 1'b1;
		#400 sda_low = 1'b0;
		#400;
	endtask : ara
endmodule : tal_smb_host
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top import tal_pkg::*;;
	logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0]        haddr, hwdata, hrdata;
	logic [1:0]         htrans;
	logic [2:0]         hsize;
	logic               conv_done, conv_busy, d_vdd, d_open, d_gnd;
	logic signed [13:0] remote_raw;
	logic [7:0]         local_temperature;
	logic               scl, host_low, sda, dat_o, dat_oe;
	logic               al_o, al_oe, cr_o, cr_oe;
	int                 miscompares, compares;

	// The data line has a pull-up; anyone driving pulls it low.
	assign sda = !(dat_oe | host_low);

	tal_alert tal_alert_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .conv_done(conv_done),
		.conv_busy(conv_busy), .remote_raw(remote_raw),
		.local_temperature(local_temperature), .diode_short_vdd(d_vdd),
		.diode_open(d_open), .diode_short_gnd(d_gnd), .smb_clk_i(scl),
		.smb_dat_i(sda), .smb_dat_o(dat_o), .smb_dat_oe(dat_oe),
		.alert_n_i(!al_oe), .alert_n_o(al_o), .alert_n_oe(al_oe),
		.critical_temp_output_n_i(!cr_oe), .critical_temp_output_n_o(cr_o),
		.critical_temp_output_n_oe(cr_oe));

	tal_smb_host tal_smb_host_i (.scl(scl), .sda_low(host_low), .sda(sda));

	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	task automatic stop_test;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic wchk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : wchk

	// Bounded wait for the slave's ready; the sampling edge passes last.
	task automatic wait_rdy;
		int n;
		n = 0;
		@(negedge hclk);
		while (hreadyout !== 1'b1) begin
			@(negedge hclk);
			n++;
			if (n > 20) begin
				wchk("hreadyout", 1, hreadyout);
				stop_test;
			end
		end
		@(posedge hclk);
	endtask : wait_rdy

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr  <= {24'h000000, a};
		wait_rdy;
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy;
		rd = hrdata;
		@(negedge hclk);
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask : wr

	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		ahb(1'b0, a, 32'h00000000, d);
		wchk(n, e, d);
	endtask : rchk

	// One conversion result, handed over with a single-cycle strobe.
	task automatic conv(input int r, input logic [7:0] l);
		@(posedge hclk);
		remote_raw        <= 14'(r);
		local_temperature <= l;
		conv_done         <= 1'b1;
		@(posedge hclk);
		conv_done <= 1'b0;
		@(posedge hclk);
		@(negedge hclk);
	endtask : conv

	task automatic t_reset;
		rchk("config", TAL_OFS_CONFIG, 32'h00);
		rchk("crit_set", TAL_OFS_CRIT_SET, 32'(TAL_RST_CRIT_SET));
		rchk("unmapped", 8'h3C, 32'h00);
		wchk("alert", 0, al_oe);
	endtask : t_reset

	task automatic critical_setpoint;
		wr(TAL_OFS_CRIT_SET, 32'h20);
		rchk("crit_lock", TAL_OFS_CRIT_SET, 32'h55);
		wr(TAL_OFS_CONFIG, 32'h02);
		wr(TAL_OFS_CRIT_SET, 32'h64);
		wr(TAL_OFS_CRIT_HYST, 32'h05);
		rchk("crit_set", TAL_OFS_CRIT_SET, 32'h64);
		conv(3200, 8'h00);
		wchk("crit_eq", 0, cr_oe);
		conv(3232, 8'h00);
		wchk("crit_on", 1, cr_oe);
		rchk("status", TAL_OFS_STATUS, 32'h12);
		conv(3072, 8'h00);
		wchk("crit_hold", 1, cr_oe);
		conv(3040, 8'h00);
		wchk("crit_off", 0, cr_oe);
		rchk("status", TAL_OFS_STATUS, 32'h10);
		wr(TAL_OFS_CONFIG, 32'h00);
	endtask : critical_setpoint

	task automatic t_irq;
		conv(2560, 8'd25);
		wchk("alert", 1, al_oe);
		rchk("status", TAL_OFS_STATUS, 32'h10);
		wchk("alert", 0, al_oe);
		rchk("config", TAL_OFS_CONFIG, 32'h01);
		rchk("status", TAL_OFS_STATUS, 32'h00);
		conv(2560, 8'd25);
		wchk("alert", 0, al_oe);
		wr(TAL_OFS_CONFIG, 32'h00);
		wchk("alert", 1, al_oe);
		wr(TAL_OFS_CONFIG, 32'h04);
		conv(800, 8'd25);
		wchk("alert", 0, al_oe);
		conv(2560, 8'd25);
		wchk("alert", 1, al_oe);
		rchk("status", TAL_OFS_STATUS, 32'h10);
		rchk("config", TAL_OFS_CONFIG, 32'h04);
		wr(TAL_OFS_CONFIG, 32'h00);
		wchk("alert", 0, al_oe);
	endtask : t_irq

	task automatic t_ara;
		logic       ack;
		logic [7:0] rx;
		conv(2560, 8'd25);
		tal_smb_host_i.ara(7, ack, rx);
		@(negedge hclk);
		wchk("ara_rx", 8'h7F, rx);
		wchk("alert", 1, al_oe);
		rchk("config", TAL_OFS_CONFIG, 32'h00);
		tal_smb_host_i.ara(-1, ack, rx);
		@(negedge hclk);
		wchk("ara_ack", 1, ack);
		wchk("ara_rx", {TAL_OWN_ADDR, 1'b1}, rx);
		wchk("alert", 0, al_oe);
		rchk("config", TAL_OFS_CONFIG, 32'h01);
		wr(TAL_OFS_CONFIG, 32'h08);
		tal_smb_host_i.ara(-1, ack, rx);
		@(negedge hclk);
		wchk("ara_ack", 0, ack);
		wchk("alert", 1, al_oe);
	endtask : t_ara

	task automatic t_fmt;
		conv(817, 8'hFB);
		rchk("rem_temp", TAL_OFS_REM_TEMP, 32'h1980);
		rchk("loc_temp", TAL_OFS_LOCAL_TEMP, 32'hFB);
		wr(TAL_OFS_CONFIG, 32'h20);
		conv(817, 8'd25);
		rchk("rem_temp", TAL_OFS_REM_TEMP, 32'h1988);
		conv(6400, 8'd25);
		rchk("rem_sat", TAL_OFS_REM_TEMP, 32'h7FF8);
		wr(TAL_OFS_CONFIG, 32'h30);
		conv(6400, 8'd25);
		rchk("rem_uns", TAL_OFS_REM_TEMP, 32'hC800);
	endtask : t_fmt

	// Low and local limits, then a diode fault with busy: no alert.
	task automatic t_fault;
		wr(TAL_OFS_CONFIG, 32'h00);
		wr(TAL_OFS_REM_LOW, 32'h0C9F);
		rchk("rem_low", TAL_OFS_REM_LOW, 32'h0C80);
		conv(320, 8'd80);
		rchk("status", TAL_OFS_STATUS, 32'h58);
		wr(TAL_OFS_CONFIG, 32'h00);
		@(posedge hclk);
		d_open    <= 1'b1;
		conv_busy <= 1'b1;
		conv(800, 8'd25);
		rchk("fault", TAL_OFS_FAULT, 32'h02);
		wchk("alert", 0, al_oe);
		rchk("status", TAL_OFS_STATUS, 32'h81);
		rchk("config", TAL_OFS_CONFIG, 32'h00);
		rchk("lines", TAL_OFS_LINES, 32'h03);
		@(posedge hclk);
		d_open    <= 1'b0;
		conv_busy <= 1'b0;
	endtask : t_fault

	initial begin
		{hresetn, hsel, hwrite, conv_done, conv_busy, d_vdd, d_open, d_gnd} = '0;
		{haddr, hwdata, htrans, remote_raw, local_temperature} = '0;
		hsize = 3'b010;
		miscompares = 0;
		compares = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(negedge hclk);
		t_reset;
		critical_setpoint;
		t_irq;
		t_ara;
		t_fmt;
		t_fault;
		stop_test;
	end
endmodule : tb_top
`default_nettype wire
